// [hdl/acs_map.svh]
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// Purpose: register index, field and reset constants of the converter sequencer.
// Assumes: byte address of a register is four times its index.
// Notes: definitions only.
`define ACS_IDX_TIMING 16'hf035
`define ACS_IDX_SELECT 16'hf036
`define ACS_IDX_DONE 16'hf037
`define ACS_IDX_RES_HI 16'hf038
`define ACS_IDX_RES_LO 16'hf039
`define ACS_IDX_EXT 16'hf03a
`define ACS_IDX_IRQ_STATUS 16'hf03b
`define ACS_IDX_IRQ_MASK 16'hf03c
`define ACS_IDX_GLOBAL 16'hf03d
`define ACS_RST_TIMING 8'h00
`define ACS_RST_SELECT 8'h00
`define ACS_RST_EXT 8'h10
`define ACS_MASK_TIMING 8'hf7
`define ACS_MASK_EXT 8'h13
`define ACS_BIT_POWER_OFF 2
`define ACS_BIT_INIT 1
`define ACS_BIT_IRQ_EN 0
`define ACS_BIT_START 0
`define ACS_BIT_ALL_EN 4
`define ACS_NUM_INPUTS 3'h6
`define ACS_CONV_BITS 10
`endif

// [hdl/acs_pkg.sv]
// Purpose: shared types of the converter sequencer.
// Assumes: used together with acs_map.svh.
// Notes: none.
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_DELAY = 2'b01,
    ACS_SAMPLE = 2'b10,
    ACS_CONVERT = 2'b11
  } acs_state_t;

  typedef struct packed {
    logic [2:0] channel;
    logic sample;
    logic compare_bit;
  } acs_core_req_t;
endpackage : acs_pkg

// [hdl/acs_sar.sv]
// Purpose: successive-approximation register producing the result word.
// Assumes: comparator input comes from the analog core, already in pclk domain after sync.
// Notes: one bit is decided per enabled clock, most significant first.
module acs_sar
  import acs_pkg::*;
#(
  parameter int WIDTH = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic start,
  input wire logic compare_high,
  output logic [WIDTH-1:0] trial,
  output logic done
);
  logic [WIDTH-1:0] bit_ptr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trial <= '0;
      bit_ptr <= '0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      if (start)
      begin
        bit_ptr <= {1'b1, {(WIDTH-1){1'b0}}};
        trial <= {1'b1, {(WIDTH-1){1'b0}}};
      end
      else if (bit_ptr != '0)
      begin
        // A low comparator means the trial overshot, so the tried bit is dropped.
        trial <= (compare_high ? trial : (trial & ~bit_ptr)) | (bit_ptr >> 1);
        bit_ptr <= bit_ptr >> 1;
        done <= (bit_ptr[0] == 1'b1);
      end
    end
  end
endmodule : acs_sar

// [hdl/acs_top.sv]
// Purpose: APB register file and sequencing control of a six-input 10-bit converter.
// Assumes: pclk 40 MHz, presetn asynchronous active low, ce freezes all state.
// Notes: the analog comparator is asynchronous and passes two flip-flops.
// Operation
// R1: Software chooses taking-part inputs through per-input enables in two registers.
// R2: Software sets power-off, init and irq enable before starting a conversion.
// R3: The delay code gives N system clocks from enable to sampling, zero for code 0.
// R4: The power-off bit powers the module off when one and resets to zero.
// R5: The init bit resets to zero and drives the power-on and initialise control.
// R6: The done interrupt reaches the processor only when global and module enables are set; completion status under mask bit 0 bypasses the module enable.
// R7: The all-inputs enable resets to one and when cleared disables every input.
// R8: The 3-bit selector picks input 0 to 5 and other codes are reserved.
// R9: Setting start begins sampling and the bit resets to zero.
// R10: Completion sets a sticky done flag that stays until software clears it.
// R11: Software waits for the done flag before reading the result.
// R12: Result bits 9 and 8 sit in bits 1 and 0 of the upper result register, rest zero.
// R13: Result bits 7 to 0 sit in the read-only lower result register.
// R14: Only one input is converted at a time through the shared sample-and-hold.
// R15: Successive approximation yields a 10-bit result kept in the result registers.
// R16: Writing zero clears the done flag, and a same-cycle completion wins.
`include "acs_map.svh"
module acs_top
  import acs_pkg::*;
#(
  parameter int RES_BITS = `ACS_CONV_BITS,
  parameter int SAMPLE_CYCLES = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic compare_in,
  output acs_core_req_t core_req,
  output logic core_power_off,
  output logic core_init,
  output logic [5:0] input_active,
  output logic irq
);
  logic [7:0] timing_reg;
  logic [7:0] select_reg;
  logic [7:0] ext_reg;
  logic done_flag;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic global_irq_en;
  logic [RES_BITS-1:0] result;
  acs_state_t state;
  logic [3:0] delay_cnt;
  logic [7:0] sample_cnt;
  logic cmp_meta;
  logic cmp_sync;
  logic sar_start;
  logic [RES_BITS-1:0] sar_trial;
  logic sar_done;
  logic [5:0] enables;
  logic sel_ok;
  logic wr;
  logic rd;
  logic [15:0] idx;
  logic conv_event;
  logic reject_event;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] want);
    hit = (a == want);
  endfunction : hit

  assign idx = paddr[17:2];
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite && ce;
  assign rd = psel && !pwrite;
  assign pslverr = psel && penable && !(hit(idx, `ACS_IDX_TIMING) || hit(idx, `ACS_IDX_SELECT) ||
    hit(idx, `ACS_IDX_DONE) || hit(idx, `ACS_IDX_RES_HI) || hit(idx, `ACS_IDX_RES_LO) ||
    hit(idx, `ACS_IDX_EXT) || hit(idx, `ACS_IDX_IRQ_STATUS) || hit(idx, `ACS_IDX_IRQ_MASK) ||
    hit(idx, `ACS_IDX_GLOBAL));

  // Comparator comes from the analog core, outside this clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end
    else if (ce)
    begin
      cmp_meta <= compare_in;
      cmp_sync <= cmp_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timing_reg <= `ACS_RST_TIMING;
      ext_reg <= `ACS_RST_EXT;
      irq_mask <= 2'h0;
      global_irq_en <= 1'b0;
    end
    else if (wr && pstrb[0])
    begin
      if (hit(idx, `ACS_IDX_TIMING))
        timing_reg <= pwdata[7:0] & `ACS_MASK_TIMING; // R3 R4 R5
      if (hit(idx, `ACS_IDX_EXT))
        ext_reg <= pwdata[7:0] & `ACS_MASK_EXT; // R1 R7
      if (hit(idx, `ACS_IDX_IRQ_MASK))
        irq_mask <= pwdata[1:0];
      if (hit(idx, `ACS_IDX_GLOBAL))
        global_irq_en <= pwdata[0];
    end
  end

  // The start bit self-clears on the first clock the sequencer is idle, whether the start is taken or refused.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      select_reg <= `ACS_RST_SELECT;
    else if (ce)
    begin
      if (wr && pstrb[0] && hit(idx, `ACS_IDX_SELECT))
        select_reg <= pwdata[7:0]; // R1 R8 R9
      else if (state == ACS_IDLE && select_reg[`ACS_BIT_START])
        select_reg[`ACS_BIT_START] <= 1'b0; // R9
    end
  end

  assign enables = {ext_reg[1:0], select_reg[7:4]} & {6{ext_reg[`ACS_BIT_ALL_EN]}}; // R7
  assign sel_ok = (select_reg[3:1] < `ACS_NUM_INPUTS) && enables[select_reg[3:1]]; // R8
  assign core_power_off = timing_reg[`ACS_BIT_POWER_OFF]; // R4
  assign core_init = timing_reg[`ACS_BIT_INIT]; // R5
  assign sar_start = (state == ACS_SAMPLE) && (sample_cnt == 8'(SAMPLE_CYCLES - 1));
  assign conv_event = (state == ACS_CONVERT) && sar_done;
  assign reject_event = (state == ACS_IDLE) && select_reg[`ACS_BIT_START] && !(sel_ok && !core_power_off);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ACS_IDLE;
      delay_cnt <= 4'h0;
      sample_cnt <= 8'h00;
    end
    else if (ce)
    begin
      case (state)
        ACS_IDLE:
        begin
          if (select_reg[`ACS_BIT_START] && sel_ok && !core_power_off) // R9
          begin
            delay_cnt <= timing_reg[7:4];
            sample_cnt <= 8'h00;
            state <= (timing_reg[7:4] == 4'h0) ? ACS_SAMPLE : ACS_DELAY; // R3
          end
        end
        ACS_DELAY:
        begin
          delay_cnt <= delay_cnt - 4'h1; // R3
          if (delay_cnt == 4'h1)
            state <= ACS_SAMPLE;
        end
        ACS_SAMPLE:
        begin
          sample_cnt <= sample_cnt + 8'h01;
          if (sar_start)
            state <= ACS_CONVERT;
        end
        ACS_CONVERT:
        begin
          if (sar_done || core_power_off)
            state <= ACS_IDLE;
        end
        default:
          state <= ACS_IDLE;
      endcase
    end
  end

  // One shared sample-and-hold, so a single input is driven active at a time.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_req <= '0;
      input_active <= 6'h00;
    end
    else if (ce)
    begin
      core_req.channel <= select_reg[3:1];
      core_req.sample <= (state == ACS_SAMPLE); // R14
      core_req.compare_bit <= (state == ACS_CONVERT);
      input_active <= (state == ACS_SAMPLE || state == ACS_CONVERT) ?
        (6'h01 << select_reg[3:1]) : 6'h00; // R14
    end
  end

  acs_sar #(
    .WIDTH(RES_BITS)
  ) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .start(sar_start),
    .compare_high(cmp_sync),
    .trial(sar_trial),
    .done(sar_done)
  ); // R15

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result <= '0;
    else if (ce && conv_event)
      result <= sar_trial; // R15
  end

  // Completion is applied after the clear so it wins a same-cycle collision.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_flag <= 1'b0;
    else if (ce)
    begin
      if (wr && pstrb[0] && hit(idx, `ACS_IDX_DONE) && !pwdata[0])
        done_flag <= 1'b0; // R16
      if (conv_event)
        done_flag <= 1'b1; // R10 R16
    end
  end

  // Status bit 0 is completion, bit 1 is a start refused for a bad selection or power off.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= 2'h0;
    else if (ce)
    begin
      if (wr && pstrb[0] && hit(idx, `ACS_IDX_IRQ_STATUS))
        irq_status <= (irq_status & ~pwdata[1:0]) | {reject_event, conv_event};
      else
        irq_status <= irq_status | {reject_event, conv_event};
    end
  end

  assign irq = global_irq_en && ((done_flag && timing_reg[`ACS_BIT_IRQ_EN]) ||
    |(irq_status & irq_mask)); // R6

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && rd && !penable)
    begin
      prdata <= 32'h0000_0000;
      if (hit(idx, `ACS_IDX_TIMING))
        prdata[7:0] <= timing_reg;
      if (hit(idx, `ACS_IDX_SELECT))
        prdata[7:0] <= select_reg;
      if (hit(idx, `ACS_IDX_DONE))
        prdata[0] <= done_flag; // R10
      if (hit(idx, `ACS_IDX_RES_HI))
        prdata[1:0] <= result[RES_BITS-1:RES_BITS-2]; // R12
      if (hit(idx, `ACS_IDX_RES_LO))
        prdata[7:0] <= result[7:0]; // R13
      if (hit(idx, `ACS_IDX_EXT))
        prdata[7:0] <= ext_reg;
      if (hit(idx, `ACS_IDX_IRQ_STATUS))
        prdata[1:0] <= irq_status;
      if (hit(idx, `ACS_IDX_IRQ_MASK))
        prdata[1:0] <= irq_mask;
      if (hit(idx, `ACS_IDX_GLOBAL))
        prdata[0] <= global_irq_en;
    end
  end
endmodule : acs_top

// [sim/acs_top_asserts.sv]
// Purpose: port-level checks of the converter sequencer.
// Assumes: the bench builds the design with a four-clock sample phase.
// Notes: attached to every acs_top instance by the bind below.
`include "acs_map.svh"
module acs_top_asserts
  import acs_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire acs_core_req_t core_req,
  input wire logic core_power_off,
  input wire logic core_init,
  input wire logic [5:0] input_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  logic [15:0] idx;
  assign wr = psel && penable && pwrite && ce && pstrb[0];
  assign idx = paddr[17:2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_power; wr && idx == `ACS_IDX_TIMING |=> core_power_off == $past(pwdata[2]); endproperty
  a_power: assert property (p_power) else $error("power-off bit wrong");
  property p_init; wr && idx == `ACS_IDX_TIMING |=> core_init == $past(pwdata[1]); endproperty
  a_init: assert property (p_init) else $error("init bit wrong");
  property p_slverr; pslverr |-> psel && penable; endproperty
  a_slverr: assert property (p_slverr) else $error("error outside access");
  property p_onehot; $onehot0(input_active); endproperty
  a_onehot: assert property (p_onehot) else $error("two inputs active");
  property p_chan; |input_active |-> input_active == (6'h01 << core_req.channel); endproperty
  a_chan: assert property (p_chan) else $error("wrong input active");
  property p_excl; !(core_req.sample && core_req.compare_bit); endproperty
  a_excl: assert property (p_excl) else $error("sample during compare");
  // The repeat count is literal; a sample length other than four needs this line changed.
  property p_sample; $rose(core_req.sample) |-> core_req.sample [*4] ##1 !core_req.sample; endproperty
  a_sample: assert property (p_sample) else $error("sample length wrong");
  property p_off; core_power_off |-> !$rose(core_req.sample); endproperty
  a_off: assert property (p_off) else $error("sampling while off");
endmodule : acs_top_asserts
bind acs_top acs_top_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_asserts (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .core_req(core_req), .core_power_off(core_power_off), .core_init(core_init),
  .input_active(input_active));

// [sim/acs_core_model.sv]
// Purpose: comparator model of the analog core.
// Assumes: the input sits above or below every trial level.
// Notes: outside sampling and conversion the output wanders, so stale values are not trusted.
module acs_core_model
  import acs_pkg::*;
(
  input wire logic pclk,
  input wire acs_core_req_t core_req,
  input wire logic level_high,
  output logic compare_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wobble = 1'b0;
  // A plain always block, since the declaration already gives wobble its start value.
  always @(posedge pclk)
    wobble <= ~wobble;
  assign compare_in = (core_req.sample || core_req.compare_bit) ? level_high : wobble;
endmodule : acs_core_model

// [sim/adc_sequencing_control_tb_top.sv]
// Purpose: self-checking bench of the converter sequencer.
// Assumes: pclk 40 MHz and a four-clock sample phase.
// Notes: the core model gives full-scale or zero inputs only.
`include "acs_map.svh"
module adc_sequencing_control_tb_top
  import acs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lvl = 1'b0, serr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, compare_in, core_power_off, core_init, irq;
  logic [5:0] input_active;
  acs_core_req_t core_req;
  int error_cnt = 0, num_checks = 0, lat0, lat;
  always #12.5 pclk = ~pclk;
  acs_top #(.SAMPLE_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .compare_in(compare_in), .core_req(core_req), .core_power_off(core_power_off),
    .core_init(core_init), .input_active(input_active), .irq(irq));
  acs_core_model u_core (.pclk(pclk), .core_req(core_req), .level_high(lvl), .compare_in(compare_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, ix, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rc(input logic [15:0] ix, input logic [7:0] e);
    apb(1'b0, ix, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rc
  task automatic poll(input logic [15:0] ix, input int b);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[b] !== 1'b1 && n < 60)
    begin
      apb(1'b0, ix, 8'h00);
      n++;
    end
  endtask : poll
  task automatic conv(input logic [2:0] sel, input logic [3:0] dly, input logic lv);
    lvl <= lv;
    apb(1'b1, `ACS_IDX_TIMING, {dly, 4'h1});
    apb(1'b1, `ACS_IDX_SELECT, {4'hf, sel, 1'b1});
    lat = 0;
    while (core_req.sample !== 1'b1 && lat < 40)
    begin
      lat++;
      @(posedge pclk);
    end
    chk({26'h0, input_active}, {26'h0, 6'h01 << sel});
    poll(`ACS_IDX_DONE, 0);
    chk(rd, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `ACS_IDX_TIMING, {dly, 4'h0});
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `ACS_IDX_GLOBAL, 8'h00);
    apb(1'b1, `ACS_IDX_TIMING, {dly, 4'h1});
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `ACS_IDX_GLOBAL, 8'h01);
    chk({31'h0, irq}, 32'h1);
    rc(`ACS_IDX_RES_HI, {6'h0, {2{lv}}});
    rc(`ACS_IDX_RES_LO, {8{lv}});
    rc(`ACS_IDX_SELECT, {4'hf, sel, 1'b0});
    apb(1'b1, `ACS_IDX_DONE, 8'h00);
    chk({31'h0, irq}, 32'h0);
  endtask : conv
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial
  begin
    #1000000;
    error_cnt++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 6; i++)
      rc(`ACS_IDX_TIMING + 16'(i), (i == 5) ? 8'h10 : 8'h00);
    apb(1'b0, 16'hf03e, 8'h00);
    chk({rd[31:1], serr}, 32'h1);
    apb(1'b1, `ACS_IDX_RES_LO, 8'h5a);
    rc(`ACS_IDX_RES_LO, 8'h00);
    apb(1'b1, `ACS_IDX_TIMING, 8'hff);
    rc(`ACS_IDX_TIMING, 8'hf7);
    chk({30'h0, core_power_off, core_init}, 32'h3);
    apb(1'b1, `ACS_IDX_EXT, 8'hff);
    rc(`ACS_IDX_EXT, 8'h13);
    apb(1'b1, `ACS_IDX_GLOBAL, 8'h01);
    for (int i = 0; i < 6; i++)
      conv(3'(i), 4'h0, i[0]);
    lat0 = lat;
    conv(3'h5, 4'hf, 1'b1);
    chk(lat - lat0, 32'd15);
    // Refused starts raise only the masked-in status bit, so stale done status is cleared first.
    apb(1'b1, `ACS_IDX_IRQ_STATUS, 8'h03);
    apb(1'b1, `ACS_IDX_IRQ_MASK, 8'h02);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `ACS_IDX_EXT, (i == 0) ? 8'h03 : 8'h13);
      apb(1'b1, `ACS_IDX_TIMING, (i == 2) ? 8'h05 : 8'h01);
      apb(1'b1, `ACS_IDX_SELECT, (i == 1) ? 8'hfd : 8'hf1);
      poll(`ACS_IDX_IRQ_STATUS, 1);
      chk(rd, 32'h2);
      chk({31'h0, irq}, 32'h1);
      rc(`ACS_IDX_SELECT, (i == 1) ? 8'hfc : 8'hf0);
      rc(`ACS_IDX_DONE, 8'h00);
      apb(1'b1, `ACS_IDX_IRQ_STATUS, 8'h02);
      chk({31'h0, irq}, 32'h0);
    end
    results();
  end
endmodule : adc_sequencing_control_tb_top
